// file: inc/tca_pkg.sv
// Purpose: Shared constants for the transfer count and activation block
// Assumes: AXI4-Lite register window with 8 decoded address bits
// Notes:   Offsets are byte addresses of aligned 32-bit words

package tca_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0]  ADDR_CRA   = 8'h00;
	localparam logic [7:0]  ADDR_CRB   = 8'h04;
	localparam logic [7:0]  ADDR_ENA0  = 8'h08; // Banks at 08,0c,10,14,18
	localparam logic [7:0]  ADDR_SAV   = 8'h1c;
	localparam logic [7:0]  ADDR_MHC   = 8'h20;
	localparam logic [7:0]  ADDR_CTRL  = 8'h24;
	localparam logic [7:0]  ADDR_STAT  = 8'h28;
	localparam logic [7:0]  ADDR_CLR   = 8'h2c;
	localparam logic [7:0]  ADDR_IEN   = 8'h30;
	localparam logic [7:0]  ADDR_STATE = 8'h34;
	localparam logic [7:0]  ADDR_VADDR = 8'h38;

	// ----------------------------------------------------------------
	// Sizes, fields and reset values
	// ----------------------------------------------------------------
	localparam int          NUM_BANKS    = 5;
	localparam int          NUM_SRC      = 40;
	localparam int          SAV_EN_BIT   = 7;
	localparam int          MHC_HALT_BIT = 14;
	localparam int          CTRL_EACH    = 2;
	localparam int          EV_END       = 0;
	localparam int          EV_EXH       = 1;
	localparam int          EV_HALT      = 2;
	localparam int          NUM_EV       = 3;
	localparam logic [15:0] MHC_RESET    = 16'h3fff;
	localparam logic [7:0]  ENA_RESET    = 8'h00;
	localparam logic [7:0]  SAV_RESET    = 8'h00;
	localparam logic [15:0] CNT_RESET    = 16'h0000;
	localparam logic [15:0] VEC_BASE     = 16'h0400;
	localparam logic [1:0]  MODE_NORMAL  = 2'h0;
	localparam logic [1:0]  MODE_REPEAT  = 2'h1;
	localparam logic [1:0]  MODE_BLOCK   = 2'h2;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// Vector table address for a 7-bit vector number
	function automatic logic [15:0] vecAddrOf(input logic [6:0] vec);
		return VEC_BASE + {8'h00, vec, 1'b0};
	endfunction

	// Byte-lane merge of a 16-bit register with write data
	function automatic logic [15:0] mergeLanes(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) res[7:0] = data[7:0];
		if (strb[1]) res[15:8] = data[15:8];
		return res;
	endfunction

endpackage

// file: src/tca_count_step.sv
// Purpose: Next-count computation for one data transfer
// Assumes: Called once per completed data transfer
// Notes:   Purely combinational; a loaded zero counts as the full range

`timescale 1ns/1ps
`default_nettype none

module tca_count_step
	import tca_pkg::*;
(
	input  wire logic [1:0]  mode,
	input  wire logic [15:0] craCur,
	input  wire logic [15:0] crbCur,
	output logic      [15:0] craNext,
	output logic      [15:0] crbNext,
	output logic             activationEnd,
	output logic             exhausted
);

	logic [7:0] lowNext;

	// ----------------------------------------------------------------
	// Count update per mode
	// ----------------------------------------------------------------
	always_comb begin
		lowNext       = craCur[7:0] - 8'h01; // 00 wraps to ff: 256 transfers
		craNext       = craCur - 16'h0001;   // 0000 wraps: 65536 transfers
		crbNext       = crbCur;
		activationEnd = 1'b1;
		exhausted     = (craNext == 16'h0000);
		if (mode == MODE_REPEAT) begin
			craNext   = {craCur[15:8], (lowNext == 8'h00) ? craCur[15:8] : lowNext};
			exhausted = 1'b0;
		end else if (mode == MODE_BLOCK) begin
			craNext       = {craCur[15:8], (lowNext == 8'h00) ? craCur[15:8] : lowNext};
			activationEnd = (lowNext == 8'h00);
			crbNext       = activationEnd ? crbCur - 16'h0001 : crbCur;
			exhausted     = activationEnd && (crbNext == 16'h0000);
		end
	end

endmodule

`default_nettype wire

// file: src/tca_src_pick.sv
// Purpose: Fixed-priority choice among enabled activation requests
// Assumes: Lowest source number has the highest priority
// Notes:   Purely combinational

`timescale 1ns/1ps
`default_nettype none

module tca_src_pick
	import tca_pkg::*;
(
	input  wire logic [NUM_SRC-1:0] srcReq,
	input  wire logic [NUM_SRC-1:0] srcEn,
	output logic                    found,
	output logic      [5:0]         srcIdx
);

	// ----------------------------------------------------------------
	// Priority search, lowest index wins
	// ----------------------------------------------------------------
	always_comb begin
		found  = 1'b0;
		srcIdx = 6'h00;
		for (int i = NUM_SRC - 1; i >= 0; i--) begin
			if (srcReq[i] && srcEn[i]) begin
				found  = 1'b1;
				srcIdx = 6'(i);
			end
		end
	end

endmodule

`default_nettype wire

// file: src/tca_top.sv
// Purpose: Transfer counting, activation enables, software activation, halt
// Assumes: Single 50 MHz clock; interrupt controller and engine on same clock
// Notes:   Registers over AXI4-Lite; standby pin is synchronised
//
// The address map and register access over AXI4-Lite were decided locally.

`timescale 1ns/1ps
`default_nettype none

module tca_top
	import tca_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic [7:0]         s_axi_awaddr,
	input  wire logic               s_axi_awvalid,
	output logic                    s_axi_awready,
	input  wire logic [31:0]        s_axi_wdata,
	input  wire logic [3:0]         s_axi_wstrb,
	input  wire logic               s_axi_wvalid,
	output logic                    s_axi_wready,
	output logic      [1:0]         s_axi_bresp,
	output logic                    s_axi_bvalid,
	input  wire logic               s_axi_bready,
	input  wire logic [7:0]         s_axi_araddr,
	input  wire logic               s_axi_arvalid,
	output logic                    s_axi_arready,
	output logic      [31:0]        s_axi_rdata,
	output logic      [1:0]         s_axi_rresp,
	output logic                    s_axi_rvalid,
	input  wire logic               s_axi_rready,
	input  wire logic               hwStandby,
	input  wire logic [NUM_SRC-1:0] srcReq,
	input  wire logic               xferDone,
	output logic                    xferReq,
	output logic      [15:0]        vecAddr,
	output logic      [5:0]         actSrc,
	output logic                    actSoft,
	output logic                    cpuIrqReq,
	output logic                    srcFlagClr,
	output logic                    moduleStop,
	output logic                    irq
);

	typedef enum logic {ST_IDLE, ST_RUN} tca_state_e;

	tca_state_e          st_q;
	logic                sb1_q, sb2_q;
	logic                bvalid_q, rvalid_q;
	logic [1:0]          bresp_q, rresp_q;
	logic [31:0]         rdata_q, rdata_d;
	logic                rdHit;
	logic [15:0]         cra_q, crb_q, craNext, crbNext;
	logic [NUM_SRC-1:0]  actEn_q;
	logic [7:0]          sav_q;
	logic                readOne_q, swPend_q;
	logic [15:0]         mhc_q, mhc_d;
	logic [2:0]          ctrl_q;
	logic [NUM_EV-1:0]   stat_q, ien_q, evSet;
	logic [15:0]         vecAddr_q;
	logic [5:0]          curSrc_q, pickIdx;
	logic                curSw_q, cpuIrq_q, flagClr_q, stop_q;
	logic                pickFound, actEnd, exhausted;
	logic                wrFire, rdFire, busy, halt, standby, eachIrq;
	logic                startHw, startSw, doneStep, endNow;

	// ----------------------------------------------------------------
	// Standby pin synchroniser
	// ----------------------------------------------------------------
	// Two flops before any use of the pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sb1_q <= 1'b0;
			sb2_q <= 1'b0;
		end else begin
			sb1_q <= hwStandby;
			sb2_q <= sb1_q;
		end
	end

	// Shared control terms
	assign standby  = sb2_q;
	assign busy     = (st_q == ST_RUN);
	assign halt     = mhc_q[MHC_HALT_BIT];
	assign eachIrq  = ctrl_q[CTRL_EACH];
	assign wrFire   = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign rdFire   = s_axi_arvalid && !rvalid_q;
	assign doneStep = busy && xferDone;
	assign endNow   = doneStep && actEnd;

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	// Address and data are taken together on the same edge
	assign s_axi_awready = wrFire;
	assign s_axi_wready  = wrFire;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rresp   = rresp_q;
	assign s_axi_rdata   = rdata_q;

	// Read mux; unmapped and write-only offsets answer with an error
	always_comb begin
		rdata_d = 32'h0000_0000;
		rdHit   = 1'b1;
		unique case (s_axi_araddr)
			ADDR_CRA:   rdata_d[15:0] = cra_q;
			ADDR_CRB:   rdata_d[15:0] = crb_q;
			ADDR_SAV:   rdata_d[7:0]  = sav_q;
			ADDR_MHC:   rdata_d[15:0] = mhc_q;
			ADDR_CTRL:  rdata_d[2:0]  = ctrl_q;
			ADDR_STAT:  rdata_d[NUM_EV-1:0] = stat_q;
			ADDR_IEN:   rdata_d[NUM_EV-1:0] = ien_q;
			ADDR_STATE: rdata_d[8:0]  = {stop_q, curSw_q, curSrc_q, busy};
			ADDR_VADDR: rdata_d[15:0] = vecAddr_q;
			default: begin
				rdHit = 1'b0;
				for (int b = 0; b < NUM_BANKS; b++) begin
					if (s_axi_araddr == ADDR_ENA0 + 8'(4 * b)) begin
						rdata_d[7:0] = actEn_q[8*b +: 8];
						rdHit        = 1'b1;
					end
				end
			end
		endcase
	end

	// Response channels
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bvalid_q <= 1'b0;
			bresp_q  <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q  <= RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
		end else begin
			if (wrFire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= (s_axi_awaddr <= ADDR_VADDR && s_axi_awaddr[1:0] == 2'h0 &&
				             s_axi_awaddr != ADDR_STAT && s_axi_awaddr != ADDR_STATE &&
				             s_axi_awaddr != ADDR_VADDR) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				bvalid_q <= 1'b0;
			end
			if (rdFire) begin
				rvalid_q <= 1'b1;
				rresp_q  <= rdHit ? RESP_OKAY : RESP_SLVERR;
				rdata_q  <= rdata_d;
			end else if (s_axi_rready) begin
				rvalid_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Counting and source selection
	// ----------------------------------------------------------------
	tca_count_step u_step (
		.mode          (ctrl_q[1:0]),
		.craCur        (cra_q),
		.crbCur        (crb_q),
		.craNext       (craNext),
		.crbNext       (crbNext),
		.activationEnd (actEnd),
		.exhausted     (exhausted)
	);

	tca_src_pick u_pick (
		.srcReq (srcReq),
		.srcEn  (actEn_q),
		.found  (pickFound),
		.srcIdx (pickIdx)
	);

	// Count registers; software writes only while idle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cra_q <= CNT_RESET;
			crb_q <= CNT_RESET;
		end else if (doneStep) begin
			cra_q <= craNext;
			crb_q <= crbNext;
		end else if (wrFire && !busy) begin
			if (s_axi_awaddr == ADDR_CRA) cra_q <= mergeLanes(cra_q, s_axi_wdata, s_axi_wstrb);
			if (s_axi_awaddr == ADDR_CRB) crb_q <= mergeLanes(crb_q, s_axi_wdata, s_axi_wstrb);
		end
	end

	// Mode and per-transfer interrupt select
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= 3'h0;
		end else if (wrFire && s_axi_awaddr == ADDR_CTRL && s_axi_wstrb[0]) begin
			ctrl_q <= s_axi_wdata[2:0];
		end
	end

	// ----------------------------------------------------------------
	// Activation enable banks
	// ----------------------------------------------------------------
	// Software writes first, end-of-activation clearing overrides
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			actEn_q <= {NUM_BANKS{ENA_RESET}};
		end else if (standby) begin
			actEn_q <= {NUM_BANKS{ENA_RESET}};
		end else begin
			for (int b = 0; b < NUM_BANKS; b++) begin
				if (wrFire && s_axi_wstrb[0] && s_axi_awaddr == ADDR_ENA0 + 8'(4 * b))
					actEn_q[8*b +: 8] <= s_axi_wdata[7:0];
			end
			if (endNow && !curSw_q && (eachIrq || exhausted))
				actEn_q[curSrc_q] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Software activation register
	// ----------------------------------------------------------------
	// Enable bit: one always taken, zero only after a read of one
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sav_q     <= SAV_RESET;
			readOne_q <= 1'b0;
			swPend_q  <= 1'b0;
		end else if (standby) begin
			sav_q     <= SAV_RESET;
			readOne_q <= 1'b0;
			swPend_q  <= 1'b0;
		end else begin
			if (rdFire && s_axi_araddr == ADDR_SAV && sav_q[SAV_EN_BIT])
				readOne_q <= 1'b1;
			if (wrFire && s_axi_awaddr == ADDR_SAV && s_axi_wstrb[0]) begin
				sav_q[6:0] <= s_axi_wdata[6:0];
				readOne_q  <= 1'b0;
				if (s_axi_wdata[SAV_EN_BIT]) begin
					sav_q[SAV_EN_BIT] <= 1'b1;
					swPend_q          <= 1'b1;
				end else if (readOne_q) begin
					sav_q[SAV_EN_BIT] <= 1'b0;
					swPend_q          <= 1'b0; // Disabled: drop a waiting start
				end
			end else if (startSw) begin
				swPend_q <= 1'b0;
			end
			if (endNow && curSw_q && !eachIrq && !exhausted)
				sav_q[SAV_EN_BIT] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Module halt control
	// ----------------------------------------------------------------
	// Halt bit cannot be raised by a write while the unit is busy
	always_comb begin
		mhc_d = mergeLanes(mhc_q, s_axi_wdata, s_axi_wstrb);
		if (busy && !halt)
			mhc_d[MHC_HALT_BIT] = 1'b0;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mhc_q <= MHC_RESET;
		end else if (standby) begin
			mhc_q <= MHC_RESET;
		end else if (wrFire && s_axi_awaddr == ADDR_MHC) begin
			mhc_q <= mhc_d;
		end
	end

	// Module stop shows once the unit is idle with halt set
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stop_q <= 1'b0;
		end else begin
			stop_q <= halt && !busy;
		end
	end

	// ----------------------------------------------------------------
	// Activation sequencing
	// ----------------------------------------------------------------
	// Interrupt sources take priority over a pending soft request
	// Source flag drops one cycle after the clear pulse; no restart meanwhile
	assign startHw = !busy && !halt && !standby && !flagClr_q && pickFound;
	assign startSw = !busy && !halt && !standby && !pickFound && swPend_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q      <= ST_IDLE;
			curSrc_q  <= 6'h00;
			curSw_q   <= 1'b0;
			vecAddr_q <= VEC_BASE;
		end else begin
			unique case (st_q)
				ST_IDLE: begin
					if (startHw) begin
						st_q      <= ST_RUN;
						curSrc_q  <= pickIdx;
						curSw_q   <= 1'b0;
						vecAddr_q <= vecAddrOf({1'b0, pickIdx});
					end else if (startSw) begin
						st_q      <= ST_RUN;
						curSw_q   <= 1'b1;
						vecAddr_q <= vecAddrOf(sav_q[6:0]);
					end
				end
				ST_RUN: begin
					if (endNow)
						st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// End-of-activation pulses to the interrupt controller
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cpuIrq_q  <= 1'b0;
			flagClr_q <= 1'b0;
		end else begin
			cpuIrq_q  <= endNow && (eachIrq || exhausted);
			flagClr_q <= endNow && !curSw_q && !eachIrq && !exhausted;
		end
	end

	// ----------------------------------------------------------------
	// Event status and interrupt
	// ----------------------------------------------------------------
	assign evSet[EV_END]  = endNow;
	assign evSet[EV_EXH]  = endNow && exhausted;
	assign evSet[EV_HALT] = halt && !busy && !stop_q;

	// Sticky status; a new event wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stat_q <= '0;
			ien_q  <= '0;
		end else begin
			if (wrFire && s_axi_awaddr == ADDR_IEN && s_axi_wstrb[0])
				ien_q <= s_axi_wdata[NUM_EV-1:0];
			if (wrFire && s_axi_awaddr == ADDR_CLR && s_axi_wstrb[0])
				stat_q <= (stat_q & ~s_axi_wdata[NUM_EV-1:0]) | evSet;
			else
				stat_q <= stat_q | evSet;
		end
	end

	// Outputs
	assign irq        = |(stat_q & ien_q);
	assign xferReq    = busy;
	assign vecAddr    = vecAddr_q;
	assign actSrc     = curSrc_q;
	assign actSoft    = curSw_q;
	assign cpuIrqReq  = cpuIrq_q;
	assign srcFlagClr = flagClr_q;
	assign moduleStop = stop_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_norm_dec;
		doneStep && ctrl_q[1:0] == MODE_NORMAL |=> cra_q == $past(cra_q) - 16'h0001;
	endproperty
	a_norm_dec: assert property (p_norm_dec) else $error("normal count not decremented");

	property p_rep_work;
		doneStep && ctrl_q[1:0] == MODE_REPEAT && cra_q[7:0] != 8'h01
			|=> cra_q[7:0] == $past(cra_q[7:0]) - 8'h01 && cra_q[15:8] == $past(cra_q[15:8]);
	endproperty
	a_rep_work: assert property (p_rep_work) else $error("working byte not decremented");

	property p_rep_reload;
		doneStep && (ctrl_q[1:0] == MODE_REPEAT || ctrl_q[1:0] == MODE_BLOCK) && cra_q[7:0] == 8'h01
			|=> cra_q[7:0] == cra_q[15:8];
	endproperty
	a_rep_reload: assert property (p_rep_reload) else $error("working byte not reloaded");

	property p_blk_end;
		doneStep && ctrl_q[1:0] == MODE_BLOCK && cra_q[7:0] == 8'h01 && crb_q == 16'h0001
			|=> st_q == ST_IDLE && crb_q == 16'h0000 && stat_q[EV_EXH];
	endproperty
	a_blk_end: assert property (p_blk_end) else $error("block sequence did not end");

	property p_en_clear;
		endNow && !curSw_q && eachIrq && !standby |=> !actEn_q[$past(curSrc_q)] && cpuIrqReq;
	endproperty
	a_en_clear: assert property (p_en_clear) else $error("enable bit kept after irq");

	property p_sav_guard;
		wrFire && s_axi_awaddr == ADDR_SAV && !s_axi_wdata[SAV_EN_BIT] && !readOne_q &&
			sav_q[SAV_EN_BIT] && !busy && !standby |=> sav_q[SAV_EN_BIT];
	endproperty
	a_sav_guard: assert property (p_sav_guard) else $error("soft enable cleared unread");

	property p_sav_quiet;
		endNow && curSw_q && !eachIrq && !exhausted |=> !sav_q[SAV_EN_BIT] && !cpuIrqReq;
	endproperty
	a_sav_quiet: assert property (p_sav_quiet) else $error("soft enable not cleared");

	property p_vec;
		startSw |=> vecAddr == VEC_BASE + {8'h00, $past(sav_q[6:0]), 1'b0} && actSoft;
	endproperty
	a_vec: assert property (p_vec) else $error("soft vector address wrong");

	property p_halt_blk;
		busy && !halt && wrFire && s_axi_awaddr == ADDR_MHC |=> !halt;
	endproperty
	a_halt_blk: assert property (p_halt_blk) else $error("halt raised while busy");

	property p_halt_stop;
		halt && !busy |=> !busy && moduleStop;
	endproperty
	a_halt_stop: assert property (p_halt_stop) else $error("halted unit started");

	property p_standby;
		standby |=> actEn_q == '0 && sav_q == SAV_RESET && mhc_q == MHC_RESET;
	endproperty
	a_standby: assert property (p_standby) else $error("standby did not clear");

	c_hw_run: cover property (startHw ##[1:20] endNow);
	c_sw_run: cover property (startSw ##[1:20] endNow);
	c_exhaust: cover property (endNow && exhausted);
	c_irq: cover property (irq);

endmodule

`default_nettype wire

// file: testbench/tca_partner.sv
// Purpose: Interrupt controller and transfer engine stand-in
// Assumes: Same clock as the block
// Notes:   Flags stay set until the block or the CPU clears them
`timescale 1ns/1ps
`default_nettype none
module tca_partner
	import tca_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic [NUM_SRC-1:0] raise,
	input  wire logic               slow,
	input  wire logic               xferReq,
	input  wire logic [5:0]         actSrc,
	input  wire logic               srcFlagClr,
	input  wire logic               cpuIrqReq,
	output logic      [NUM_SRC-1:0] srcReq,
	output logic                    xferDone
);
	logic [4:0] waitQ;
	// Sticky flags; one transfer pulse after a short or long wait
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			srcReq   <= '0;
			waitQ    <= '0;
			xferDone <= 1'b0;
		end else begin
			srcReq   <= srcReq | raise;
			if (srcFlagClr || cpuIrqReq) srcReq[actSrc] <= 1'b0;
			xferDone <= xferReq && !xferDone && waitQ == (slow ? 5'd20 : 5'd1);
			waitQ    <= (!xferReq || xferDone) ? 5'd0 : waitQ + 5'd1;
		end
	end
endmodule
`default_nettype wire

// file: testbench/test_transfer_count_activation_regs.sv
// Purpose: Self-checking bench for the count and activation block
// Assumes: One 50 MHz clock; fixed seed
// Notes:   Expected values come from bench tables and functions
`timescale 1ns/1ps
`default_nettype none
module test_transfer_count_activation_regs
	import tca_pkg::*;
();
	logic        clk, rst_n, hwStandby, slow, xferDone, xferReq, actSoft;
	logic        cpuIrqReq, srcFlagClr, moduleStop, irq, s_axi_awvalid, s_axi_awready;
	logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [3:0]  s_axi_wstrb;
	logic [5:0]  actSrc;
	logic [6:0]  v;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [15:0] vecAddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, lfsr;
	logic [39:0] srcReq, raise;
	int          numErrors, testsRun, irqCnt, clrCnt, c0, c1, i;
	// Mode, count A, count B, expected A, expected B, soft bit kept
	localparam logic [15:0] TBL [5][6] = '{
		'{16'h0, 16'h0005, 16'h0000, 16'h0004, 16'h0000, 16'h0},
		'{16'h1, 16'h0301, 16'h0000, 16'h0303, 16'h0000, 16'h0},
		'{16'h1, 16'h0500, 16'h0000, 16'h05ff, 16'h0000, 16'h0},
		'{16'h2, 16'h0202, 16'h0002, 16'h0202, 16'h0001, 16'h0},
		'{16'h2, 16'h0101, 16'h0001, 16'h0101, 16'h0000, 16'h1}};
	tca_top dut_u (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .hwStandby, .srcReq, .xferDone, .xferReq, .vecAddr, .actSrc, .actSoft,
		.cpuIrqReq, .srcFlagClr, .moduleStop, .irq);
	tca_partner part_u (.clk, .rst_n, .raise, .slow, .xferReq, .actSrc, .srcFlagClr,
		.cpuIrqReq, .srcReq, .xferDone);
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] expVec(input logic [6:0] n);
		return 32'h0400 + {24'h0, n, 1'b0};
	endfunction
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		testsRun++;
		if (g !== e) begin
			numErrors++;
			$display("ERROR %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge clk);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		do @(posedge clk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid  <= 1'b0;
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready  <= 1'b0;
		chk("bresp", 32'(er), 32'(s_axi_bresp));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready  <= 1'b0;
		chk("rdata", e, s_axi_rdata);
		chk("rresp", 32'(er), 32'(s_axi_rresp));
	endtask
	// Raise one source flag for a single clock cycle
	task automatic kick(input int n);
		@(posedge clk);
		raise <= 40'h1 << n;
		@(posedge clk);
		raise <= '0;
	endtask
	task automatic waitLvl(input logic lv);
		while (xferReq !== lv) @(posedge clk);
		if (!lv) repeat (2) @(posedge clk);
	endtask
	task automatic wrapUp();
		if (numErrors == 0 && testsRun > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Clock, CPU interrupt and source flag clear counters and hang guard
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) if (cpuIrqReq === 1'b1) irqCnt <= irqCnt + 1;
	always @(posedge clk) if (srcFlagClr === 1'b1) clrCnt <= clrCnt + 1;
	initial begin
		repeat (20000) @(posedge clk);
		numErrors++;
		wrapUp();
	end
	// Main sequence
	initial begin
		{rst_n, hwStandby, slow, s_axi_awvalid, s_axi_wvalid, s_axi_bready, raise} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hf;
		lfsr = 32'hc073cee6;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(ADDR_MHC, 32'h3fff, RESP_OKAY);
		rd(ADDR_SAV, 32'h0, RESP_OKAY);
		rd(8'hfc, 32'h0, RESP_SLVERR);
		wr(ADDR_STAT, 32'h1, RESP_SLVERR);
		for (i = 0; i < NUM_BANKS; i++) begin
			lfsr = nxt(lfsr);
			rd(ADDR_ENA0 + 8'(4 * i), 32'h0, RESP_OKAY);
			wr(ADDR_ENA0 + 8'(4 * i), {24'h0, lfsr[7:0]}, RESP_OKAY);
			rd(ADDR_ENA0 + 8'(4 * i), {24'h0, lfsr[7:0]}, RESP_OKAY);
			wr(ADDR_ENA0 + 8'(4 * i), 32'h0, RESP_OKAY);
		end
		wr(ADDR_IEN, 32'h3, RESP_OKAY);
		wr(ADDR_CRA, 32'h2, RESP_OKAY);
		for (i = 0; i < 2; i++) begin
			c0 = irqCnt;
			c1 = clrCnt;
			wr(ADDR_ENA0, 32'h8, RESP_OKAY);
			kick(3);
			waitLvl(1'b1);
			chk("vecAddr", expVec(7'h3), 32'(vecAddr));
			chk("actSrc", 32'h3, 32'(actSrc));
			waitLvl(1'b0);
			rd(ADDR_CRA, 32'(1 - i), RESP_OKAY);
			rd(ADDR_ENA0, i ? 32'h0 : 32'h8, RESP_OKAY);
			chk("cpuIrq", 32'(c0 + i), 32'(irqCnt));
			chk("flagClr", 32'(c1 + 1 - i), 32'(clrCnt));
		end
		rd(ADDR_STAT, 32'h3, RESP_OKAY);
		chk("irq", 32'h1, 32'(irq));
		wr(ADDR_CLR, 32'h3, RESP_OKAY);
		chk("irq", 32'h0, 32'(irq));
		c0 = irqCnt;
		wr(ADDR_CTRL, 32'h4, RESP_OKAY);
		wr(ADDR_CRA, 32'h5, RESP_OKAY);
		wr(ADDR_ENA0, 32'h8, RESP_OKAY);
		kick(3);
		waitLvl(1'b1);
		waitLvl(1'b0);
		chk("cpuIrq", 32'(c0 + 1), 32'(irqCnt));
		rd(ADDR_ENA0, 32'h0, RESP_OKAY);
		wr(ADDR_IEN, 32'h0, RESP_OKAY);
		for (i = 0; i < 5; i++) begin
			lfsr = nxt(lfsr);
			v = i ? lfsr[6:0] : 7'h10;
			wr(ADDR_CTRL, 32'(TBL[i][0]), RESP_OKAY);
			wr(ADDR_CRA, 32'(TBL[i][1]), RESP_OKAY);
			wr(ADDR_CRB, 32'(TBL[i][2]), RESP_OKAY);
			wr(ADDR_SAV, {24'h0, 1'b1, v}, RESP_OKAY);
			waitLvl(1'b1);
			chk("vecAddr", expVec(v), 32'(vecAddr));
			chk("actSoft", 32'h1, 32'(actSoft));
			waitLvl(1'b0);
			rd(ADDR_CRA, 32'(TBL[i][3]), RESP_OKAY);
			rd(ADDR_CRB, 32'(TBL[i][4]), RESP_OKAY);
			rd(ADDR_SAV, {24'h0, TBL[i][5][0], v}, RESP_OKAY);
		end
		chk("irq", 32'h0, 32'(irq));
		slow <= 1'b1;
		wr(ADDR_CTRL, 32'h0, RESP_OKAY);
		wr(ADDR_ENA0, 32'h8, RESP_OKAY);
		kick(3);
		waitLvl(1'b1);
		wr(ADDR_MHC, 32'h7fff, RESP_OKAY);
		rd(ADDR_MHC, 32'h3fff, RESP_OKAY);
		waitLvl(1'b0);
		slow <= 1'b0;
		wr(ADDR_MHC, 32'h7fff, RESP_OKAY);
		repeat (2) @(posedge clk);
		chk("moduleStop", 32'h1, 32'(moduleStop));
		wr(ADDR_SAV, 32'h85, RESP_OKAY);
		wr(ADDR_SAV, 32'h05, RESP_OKAY);
		chk("xferReq", 32'h0, 32'(xferReq));
		rd(ADDR_SAV, 32'h85, RESP_OKAY);
		wr(ADDR_SAV, 32'h05, RESP_OKAY);
		rd(ADDR_SAV, 32'h05, RESP_OKAY);
		// Hardware standby pulse returns enables, soft vector and halt control
		hwStandby <= 1'b1;
		repeat (4) @(posedge clk);
		hwStandby <= 1'b0;
		repeat (3) @(posedge clk);
		rd(ADDR_MHC, 32'h3fff, RESP_OKAY);
		rd(ADDR_SAV, 32'h0, RESP_OKAY);
		rd(ADDR_ENA0, 32'h0, RESP_OKAY);
		wr(ADDR_MHC, 32'h3fff, RESP_OKAY);
		repeat (2) @(posedge clk);
		chk("moduleStop", 32'h0, 32'(moduleStop));
		wrapUp();
	end
endmodule
`default_nettype wire
